// ===== design/clbi_config_bank.sv
// Purpose: Write-only configuration latch banks for a four-channel transceiver
// Assumes: Write strobe, address and data synchronous to clk_i
// Notes: Writes are level sensitive, one load per clock while strobe low
`timescale 1ns/1ps
`include "clbi_regs.svh"

module clbi_config_bank #(
   parameter int NUM_CHAN = `CLBI_NUM_CHAN
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic config_write_strobe_n_i,
   input wire logic [3:0] bank_addr_i,
   input wire logic [7:0] bank_data_i,
   input wire logic [39:0] rx_char_i,
   output logic [95:0] config_bank_o,
   output logic [7:0] reframe_select_o,
   output logic [3:0] framing_pattern_select_o,
   output logic [3:0] decode_table_select_o,
   output logic [3:0] decoder_enable_o,
   output logic [3:0] framing_match_flag_o
);

   clbi_pkg::clbi_state_t st_r;
   clbi_pkg::clbi_state_t st_nxt;

   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] mask_v);
      merge = (old_v & ~mask_v) | (new_v & mask_v);
   endfunction

   function automatic logic pattern_hit(input logic [9:0] ch,
                                        input logic k_sel);
      if (k_sel) begin
         pattern_hit = (ch == `CLBI_K285_NEG) ||
                       (ch == `CLBI_K285_POS);
      end else begin
         pattern_hit = (ch[6:0] == `CLBI_COMMA_NEG) ||
                       (ch[6:0] == `CLBI_COMMA_POS);
      end
   endfunction

   function automatic clbi_pkg::clbi_banks_t reset_banks();
      clbi_pkg::clbi_banks_t b;
      b = '0;
      for (int c = 0; c < `CLBI_NUM_CHAN; c++) begin
         b[c*3] = `CLBI_RST_RX_STATIC;
         b[c*3+1] = `CLBI_RST_TX_STATIC;
         b[c*3+2] = `CLBI_RST_DYNAMIC;
      end
      b[12] = `CLBI_RST_GLOBAL;
      b[13] = `CLBI_RST_GLOBAL;
      b[14] = `CLBI_RST_GLOBAL;
      b[15] = `CLBI_RST_MASK;
      return b;
   endfunction

   always_comb begin
      logic [7:0] mask_v;
      logic [7:0] tgt_v;
      logic [3:0] grp;
      logic [3:0] tgt;
      logic force_v;
      mask_v = st_r.bank[15];
      tgt_v = '0;
      grp = '0;
      tgt = '0;
      force_v = 1'b0;
      st_nxt = st_r;
      // Level write: holding the strobe repeats an idempotent load
      if (!config_write_strobe_n_i) begin
         if (bank_addr_i == `CLBI_ADDR_MASK) begin
            st_nxt.bank[15] = bank_data_i;
         end else begin
            st_nxt.bank[bank_addr_i] = merge(st_r.bank[bank_addr_i],
                                             bank_data_i, mask_v);
            if (bank_addr_i >= `CLBI_ADDR_GLOBAL_FIRST) begin
               grp = bank_addr_i - `CLBI_ADDR_GLOBAL_FIRST;
               // Force comes from the written data, so mask bit 0 is moot
               force_v = bank_data_i[`CLBI_BIT_FORCE_GROUP];
               for (int c = 0; c < `CLBI_NUM_CHAN; c++) begin
                  tgt = 4'(c * 3) + grp;
                  if (force_v ||
                      st_r.bank[tgt][`CLBI_BIT_GROUP_ACCEPT]) begin
                     tgt_v = merge(st_r.bank[tgt], bank_data_i, mask_v);
                     tgt_v[`CLBI_BIT_GROUP_ACCEPT] =
                        st_r.bank[tgt][`CLBI_BIT_GROUP_ACCEPT];
                     st_nxt.bank[tgt] = tgt_v;
                  end
               end
            end
         end
      end
      for (int c = 0; c < `CLBI_NUM_CHAN; c++) begin
         // Character is taken as already framed on its proper boundary
         st_nxt.flag[c] =
            !st_r.bank[c*3][`CLBI_BIT_DECODER_EN] &&
            pattern_hit(rx_char_i[c*10 +: 10],
                        st_r.bank[c*3][`CLBI_BIT_FRAMING_SEL]);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r.bank <= reset_banks();
         st_r.flag <= 4'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // No addressed read port; banks 0 to 11 also leave raw on config_bank_o besides the decoded settings
   assign config_bank_o = st_r.bank[11:0];
   assign framing_match_flag_o = st_r.flag;

   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_fields
      // Framer consumes 00, 01, 10; 11 is left to the controller to avoid
      assign reframe_select_o[c*2 +: 2] =
         st_r.bank[c*3][`CLBI_BIT_REFRAME_HI:`CLBI_BIT_REFRAME_LO];
      assign framing_pattern_select_o[c] =
         st_r.bank[c*3][`CLBI_BIT_FRAMING_SEL];
      assign decode_table_select_o[c] =
         st_r.bank[c*3][`CLBI_BIT_DECODE_TABLE];
      assign decoder_enable_o[c] =
         st_r.bank[c*3][`CLBI_BIT_DECODER_EN];
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   logic wr;
   assign wr = !config_write_strobe_n_i;

   a_mask_unmasked: assert property (
      wr && bank_addr_i == 4'hf |=> st_r.bank[15] == $past(bank_data_i))
      else $error("mask bank write was altered");

   a_direct_full: assert property (
      wr && bank_addr_i < 4'hc && st_r.bank[15] == 8'hff
      |=> st_r.bank[$past(bank_addr_i)] == $past(bank_data_i))
      else $error("direct write not loaded");

   a_mask_keeps: assert property (
      wr && bank_addr_i == 4'h0 && !st_r.bank[15][7]
      |=> st_r.bank[0][7] == $past(st_r.bank[0][7]))
      else $error("masked bit changed");

   a_accept_kept: assert property (
      wr && bank_addr_i == 4'hc
      |=> st_r.bank[3][0] == $past(st_r.bank[3][0]) &&
          st_r.bank[9][0] == $past(st_r.bank[9][0]))
      else $error("global write changed accept bit");

   a_blocked_target: assert property (
      wr && bank_addr_i == 4'hc && !bank_data_i[0] && !st_r.bank[3][0]
      |=> $stable(st_r.bank[3]))
      else $error("global write reached blocked bank");

   a_forced_target: assert property (
      wr && bank_addr_i == 4'hd && bank_data_i[0] &&
      st_r.bank[15] == 8'hfe
      |=> st_r.bank[4][7:1] == $past(bank_data_i[7:1]) &&
          st_r.bank[10][7:1] == $past(bank_data_i[7:1]))
      else $error("forced global write missed target");

   a_fanout_accept: assert property (
      wr && bank_addr_i == 4'he && st_r.bank[11][0] &&
      st_r.bank[15] == 8'hff
      |=> st_r.bank[11][7:1] == $past(bank_data_i[7:1]))
      else $error("dynamic fanout missed bank 11");

   a_idle_hold: assert property (
      !wr |=> $stable(st_r.bank))
      else $error("bank changed without strobe");

   a_repeat_write: assert property (
      wr ##1 wr && $stable(bank_addr_i) && $stable(bank_data_i)
      |=> $stable(st_r.bank))
      else $error("repeated write had side effect");

   a_flag_decoder: assert property (
      decoder_enable_o[0] |=> !framing_match_flag_o[0])
      else $error("match flag set with decoder enabled");

   a_flag_k285: assert property (
      !decoder_enable_o[0] && framing_pattern_select_o[0] &&
      rx_char_i[9:0] == 10'h17c |=> framing_match_flag_o[0])
      else $error("K28.5 not flagged in bypass");

   a_flag_comma: assert property (
      !decoder_enable_o[1] && !framing_pattern_select_o[1] &&
      rx_char_i[16:10] == 7'h7c |=> framing_match_flag_o[1])
      else $error("comma not flagged in bypass");

   a_flag_nomatch: assert property (
      !decoder_enable_o[0] && framing_pattern_select_o[0] &&
      rx_char_i[9:0] != 10'h17c && rx_char_i[9:0] != 10'h283
      |=> !framing_match_flag_o[0])
      else $error("match flag set without framing pattern");

   a_global_stored: assert property (
      wr && bank_addr_i >= 4'hc && bank_addr_i <= 4'he &&
      st_r.bank[15] == 8'hff
      |=> st_r.bank[$past(bank_addr_i)] == $past(bank_data_i))
      else $error("global bank not loaded");

   a_other_banks: assert property (
      wr && bank_addr_i == 4'hc
      |=> $stable(st_r.bank[1]) && $stable(st_r.bank[11]))
      else $error("global write reached non-target bank");

   a_direct_only: assert property (
      wr && bank_addr_i == 4'h4
      |=> $stable(st_r.bank[1]) && $stable(st_r.bank[7]) &&
          $stable(st_r.bank[15]))
      else $error("direct write reached another bank");

   a_force_nomask: assert property (
      wr && bank_addr_i == 4'hc && bank_data_i[0] &&
      st_r.bank[15] == 8'hfe
      |=> st_r.bank[0][7:1] == $past(bank_data_i[7:1]) &&
          st_r.bank[9][7:1] == $past(bank_data_i[7:1]))
      else $error("forced write blocked by mask bit 0");

   a_force_accept: assert property (
      wr && bank_addr_i == 4'he && bank_data_i[0]
      |=> st_r.bank[2][0] == $past(st_r.bank[2][0]) &&
          st_r.bank[8][0] == $past(st_r.bank[8][0]))
      else $error("forced write changed accept bit");

   a_blocked_dyn: assert property (
      wr && bank_addr_i == 4'he && !bank_data_i[0] && !st_r.bank[5][0]
      |=> $stable(st_r.bank[5]))
      else $error("global write reached blocked dynamic bank");

   a_live_dynamic: assert property (
      wr && bank_addr_i == 4'he && st_r.bank[2][0] &&
      st_r.bank[15] == 8'hff
      |=> st_r.bank[2][7:1] == $past(bank_data_i[7:1]))
      else $error("live dynamic control missed bank 2");

   a_accept_direct: assert property (
      wr && bank_addr_i == 4'h0 && st_r.bank[15][0]
      |=> st_r.bank[0][0] == $past(bank_data_i[0]))
      else $error("direct write did not set accept bit");

   a_mask_no_fanout: assert property (
      wr && bank_addr_i == 4'hf |=> $stable(st_r.bank[14:0]))
      else $error("mask write reached other banks");

   a_mask_partial: assert property (
      wr && bank_addr_i == 4'h1 && st_r.bank[15] == 8'h0f
      |=> st_r.bank[1][7:4] == $past(st_r.bank[1][7:4]) &&
          st_r.bank[1][3:0] == $past(bank_data_i[3:0]))
      else $error("partial mask misapplied");

   a_global_masked: assert property (
      wr && bank_addr_i == 4'hd && st_r.bank[15] == 8'hf0 &&
      st_r.bank[4][0]
      |=> st_r.bank[4][3:1] == $past(st_r.bank[4][3:1]))
      else $error("mask ignored on global write");

   a_reframe_map: assert property (
      wr && bank_addr_i == 4'h9 && st_r.bank[15] == 8'hff
      |=> reframe_select_o[7:6] == $past(bank_data_i[2:1]))
      else $error("reframe select not taken from bank 9");

   a_frame_sel_map: assert property (
      wr && bank_addr_i == 4'h3 && st_r.bank[15] == 8'hff
      |=> framing_pattern_select_o[1] == $past(bank_data_i[3]))
      else $error("framing select not taken from bank 3");

   a_table_sel_map: assert property (
      wr && bank_addr_i == 4'h6 && st_r.bank[15] == 8'hff
      |=> decode_table_select_o[2] == $past(bank_data_i[4]))
      else $error("decode table select not taken from bank 6");

   a_dec_en_map: assert property (
      wr && bank_addr_i == 4'h9 && st_r.bank[15] == 8'hff
      |=> decoder_enable_o[3] == $past(bank_data_i[5]))
      else $error("decoder enable not taken from bank 9");

   // Sampled state at the release edge still shows the reset load
   a_reset_values: assert property (
      $rose(reset_n_i) |-> st_r.bank[15] == `CLBI_RST_MASK &&
      st_r.bank[0] == `CLBI_RST_RX_STATIC &&
      st_r.bank[5] == `CLBI_RST_DYNAMIC)
      else $error("banks not at reset values");

   a_reset_outputs: assert property (
      $rose(reset_n_i) |-> framing_match_flag_o == 4'h0 &&
      decoder_enable_o == 4'hf && reframe_select_o == 8'haa)
      else $error("outputs not at reset values");

   c_forced_global: cover property (
      wr && bank_addr_i == 4'hc && bank_data_i[0]);
   c_live_dynamic: cover property (
      (wr && bank_addr_i == 4'he) [*3]);
   c_mask_partial: cover property (
      wr && bank_addr_i == 4'h1 && st_r.bank[15] != 8'hff);
   c_bypass_match: cover property (framing_match_flag_o[2]);
   c_force_masked: cover property (
      wr && bank_addr_i == 4'hc && bank_data_i[0] && !st_r.bank[15][0]);

endmodule // clbi_config_bank

// ===== design/clbi_regs.svh
// Purpose: Offsets, field positions and reset values of the config banks
// Assumes: Banks are 8 bits wide, addressed by a 4-bit bank number
// Notes: Field positions inside per-channel banks are fixed here
`ifndef CLBI_REGS_SVH
`define CLBI_REGS_SVH

`define CLBI_NUM_BANKS 16
`define CLBI_NUM_CHAN 4
`define CLBI_BANKS_PER_CHAN 3
`define CLBI_CHAN_BANKS 12
`define CLBI_ADDR_GLOBAL_FIRST 4'hc
`define CLBI_ADDR_GLOBAL_SECOND 4'hd
`define CLBI_ADDR_GLOBAL_DYNAMIC 4'he
`define CLBI_ADDR_MASK 4'hf

`define CLBI_BIT_GROUP_ACCEPT 0
`define CLBI_BIT_FORCE_GROUP 0
`define CLBI_BIT_REFRAME_LO 1
`define CLBI_BIT_REFRAME_HI 2
`define CLBI_BIT_FRAMING_SEL 3
`define CLBI_BIT_DECODE_TABLE 4
`define CLBI_BIT_DECODER_EN 5

`define CLBI_RST_RX_STATIC 8'h3d
`define CLBI_RST_TX_STATIC 8'h01
`define CLBI_RST_DYNAMIC 8'h01
`define CLBI_RST_GLOBAL 8'h00
`define CLBI_RST_MASK 8'hff

`define CLBI_K285_NEG 10'h17c
`define CLBI_K285_POS 10'h283
`define CLBI_COMMA_NEG 7'h7c
`define CLBI_COMMA_POS 7'h03

`endif

// ===== design/clbi_pkg.sv
// Purpose: Types shared by the configuration latch bank
// Assumes: Used with clbi_regs.svh
// Notes: All block state lives in one packed struct
package clbi_pkg;
   typedef logic [15:0][7:0] clbi_banks_t;
   typedef struct packed {
      clbi_banks_t bank;
      logic [3:0] flag;
   } clbi_state_t;
endpackage

// ===== testbench/clbi_host_model.sv
// Purpose: Host controller model driving the config write bus
// Assumes: Tasks are entered at a falling clock edge
// Notes: Steers clear of the reserved reframe code on writes to banks 0, 3, 6, 9 and 12
`timescale 1ns/1ps
module clbi_host_model (
   input wire logic clk_i,
   output logic strobe_n_o,
   output logic [3:0] addr_o,
   output logic [7:0] data_o
);
   initial begin
      strobe_n_o = 1'b1;
      addr_o = 4'h0;
      data_o = 8'h00;
   end

   // Last=0 keeps strobe low so the next call continues the burst
   task automatic send(input logic [3:0] a, inout logic [7:0] d,
                       input bit last);
      if (a < 4'hd && a % 3 == 0 && d[2:1] == 2'b11) begin
         d[1] = 1'b0;
      end
      strobe_n_o = 1'b0;
      addr_o = a;
      data_o = d;
      @(negedge clk_i);
      if (last) begin
         strobe_n_o = 1'b1;
         @(negedge clk_i);
      end
   endtask
endmodule // clbi_host_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the config latch banks
// Assumes: Inputs change at the falling edge
// Notes: Integer bank model mirrors every write
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic strobe_n;
   logic [3:0] addr;
   logic [7:0] data;
   logic [39:0] rx_char = 40'h0;
   logic [95:0] bank_o;
   logic [7:0] rf_o;
   logic [3:0] fs_o, dt_o, de_o, fm_o;
   int err_total = 0;
   int comparisons = 0;
   int mdl [16];
   logic [7:0] pat_d [4] = '{8'h09, 8'h01, 8'h29, 8'h05};

   always #4 clk_i = ~clk_i;

   clbi_config_bank uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .config_write_strobe_n_i(strobe_n), .bank_addr_i(addr),
      .bank_data_i(data), .rx_char_i(rx_char), .config_bank_o(bank_o),
      .reframe_select_o(rf_o), .framing_pattern_select_o(fs_o),
      .decode_table_select_o(dt_o), .decoder_enable_o(de_o),
      .framing_match_flag_o(fm_o));

   clbi_host_model host (.clk_i(clk_i), .strobe_n_o(strobe_n),
      .addr_o(addr), .data_o(data));

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_all();
      for (int k = 0; k < 12; k++) begin
         chk("bank", mdl[k], bank_o[8*k +: 8]);
      end
      for (int c = 0; c < 4; c++) begin
         chk("reframe", mdl[3*c] >> 1 & 3, rf_o[2*c +: 2]);
         chk("fields", mdl[3*c] >> 3 & 7, {de_o[c], dt_o[c], fs_o[c]});
      end
   endtask

   task automatic mdl_reset();
      for (int k = 0; k < 16; k++) begin
         mdl[k] = (k == 15) ? 255 : (k >= 12) ? 0 : (k % 3 == 0) ? 'h3d : 1;
      end
   endtask

   task automatic mdl_write(input int a, input int d);
      int m;
      int t;
      m = (a == 15) ? 255 : mdl[15];
      mdl[a] = (mdl[a] & ~m | d & m) & 255;
      if (a >= 12 && a <= 14) begin
         for (int c = 0; c < 4; c++) begin
            t = 3 * c + a - 12;
            if (mdl[t][0] || d[0]) begin
               mdl[t] = (mdl[t] & ~m | d & m) & 254 | mdl[t] & 1;
            end
         end
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input bit last);
      host.send(a, d, last);
      mdl_write(a, d);
      chk_all();
   endtask

   task automatic flag_run();
      logic [9:0] pat [4] = '{10'h17c, 10'h283, 10'h37c, 10'h203};
      logic [9:0] ch;
      bit hit;
      repeat (30) begin
         for (int c = 0; c < 4; c++) begin
            rx_char[10*c +: 10] = ($urandom % 2) ? pat[$urandom % 4]
                                                 : 10'($urandom);
         end
         @(negedge clk_i);
         for (int c = 0; c < 4; c++) begin
            ch = rx_char[10*c +: 10];
            hit = mdl[3*c][3] ? (ch == 10'h17c || ch == 10'h283)
                              : (ch[6:0] == 7'h7c || ch[6:0] == 7'h03);
            chk("flag", {7'h0, !mdl[3*c][5] && hit}, {7'h0, fm_o[c]});
         end
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_total++;
      final_report();
   end

   initial begin
      void'($urandom(32'hfd52));
      mdl_reset();
      repeat (3) @(negedge clk_i);
      reset_n_i = 1'b1;
      chk_all();
      chk("flag", 8'h00, {4'h0, fm_o});
      $display("test reset done");
      wr(4'h3, 8'h02, 1);
      wr(4'hc, 8'h3a, 1);
      wr(4'hc, 8'h15, 1);
      wr(4'he, 8'h81, 1);
      $display("test global done");
      wr(4'hf, 8'hf0, 1);
      wr(4'h0, 8'h0f, 1);
      wr(4'hc, 8'hcd, 1);
      wr(4'hf, 8'hff, 1);
      $display("test mask done");
      repeat (6) wr(4'he, 8'($urandom), 0);
      repeat (3) wr(4'h5, 8'h5a, 0);
      wr(4'h5, 8'h5a, 1);
      $display("test burst done");
      repeat (200) wr(4'($urandom), 8'($urandom), 1'($urandom));
      wr(4'hf, 8'hff, 1);
      $display("test random done");
      reset_n_i = 1'b0;
      @(negedge clk_i);
      mdl_reset();
      reset_n_i = 1'b1;
      chk_all();
      chk("flag", 8'h00, {4'h0, fm_o});
      $display("test midreset done");
      foreach (pat_d[i]) begin
         wr(4'hc, pat_d[i], 1);
         flag_run();
      end
      $display("test flag done");
      final_report();
   end
endmodule // tb
